// >>> rtl/srb_pkg.sv
package srb_pkg;
	// clock rate and printed times
	localparam int CLK_MHZ = 200;
	localparam int QUAL_TIME_MS = 10;
	localparam int BOOT_DELAY_MS = 200;
	localparam int RETRY_TIME_MS = 1000;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;

	// timer width covers the one-second retry at 200 MHz
	localparam int TMR_W = 28;
	localparam logic [TMR_W-1:0] QUAL_CYC = TMR_W'(QUAL_TIME_MS * CYC_PER_MS);
	localparam logic [TMR_W-1:0] BOOT_DELAY_CYC = TMR_W'(BOOT_DELAY_MS * CYC_PER_MS);
	localparam logic [TMR_W-1:0] RETRY_CYC = TMR_W'(RETRY_TIME_MS * CYC_PER_MS);

	// eeprom image layout: marker word, length word, payload, checksum word
	localparam int WORD_W = 16;
	localparam int EEP_AW = 16;
	localparam int PROGRAM_RAM_AW = 14;
	localparam logic [WORD_W-1:0] PROGRAM_RAM_DEPTH = 16'h3000;
	localparam logic [WORD_W-1:0] BOOT_MARKER = 16'hA5C3; // arbitrary value
	localparam logic [EEP_AW-1:0] IDX_MARKER = 16'h0000;
	localparam logic [EEP_AW-1:0] IDX_LENGTH = 16'h0001;
	localparam logic [EEP_AW-1:0] IMG_HDR_WORDS = 16'h0002;
	localparam logic [PROGRAM_RAM_AW-1:0] BOOT_START_ADDR = 14'h0000;

	typedef enum logic [1:0] {PS_OFF, PS_POR, PS_RUN} srb_sup_state_t;
	typedef enum logic [2:0] {BT_IDLE, BT_DELAY, BT_REQ, BT_WAIT, BT_PC, BT_DONE, BT_RETRY} srb_boot_state_t;

	typedef struct packed {
		logic req;
		logic [EEP_AW-1:0] addr;
	} srb_eep_req_t;

	typedef struct packed {
		logic valid;
		logic err;
		logic [WORD_W-1:0] data;
	} srb_eep_ans_t;

	typedef struct packed {
		logic we;
		logic [PROGRAM_RAM_AW-1:0] addr;
		logic [WORD_W-1:0] data;
	} srb_program_ram_wr_t;
endpackage : srb_pkg

// >>> rtl/srb_timer.sv
`timescale 1ns/1ps
module srb_timer
	import srb_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic clear,
	input wire logic run,
	input wire logic [srb_pkg::TMR_W-1:0] limit,
	// status
	output logic done
);
	logic [TMR_W-1:0] cnt_r;

	// counts run cycles, saturates at the limit, holds while run is low
	always_ff @(posedge clk)
	begin
		if (rst || clear)
			cnt_r <= '0;
		else if (run && !done)
			cnt_r <= cnt_r + TMR_W'(1);
	end

	assign done = (cnt_r == limit);
endmodule : srb_timer

// >>> rtl/srb_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] a power-up reset pulse returns every control and core register to default
// [RULE_02] audio outputs stay muted through power-on until software releases them
// [RULE_03] first eeprom read starts 200 ms after the power-up reset
// [RULE_04] image is checked whole first; only a validated image is written to program_ram
// [RULE_05] on an eeprom read error outputs mute and boot retries after one second
// [RULE_06] after loading, program counter is loaded with the bootloader start address
// [RULE_07] power-up reset only after supply above start level for qualification time
// [RULE_08] supply below off level shuts down all functional units including audio
// [RULE_09] after shutdown, a new power-up reset needs a fresh qualification
// [RULE_10] once running, only falling below the lower off level powers down
// [RULE_11] qualification timer restarts when supply drops below off level early
// [RULE_12] boot retries repeat forever, each from the first boot stage
module srb_sequencer
	import srb_pkg::*;
#(
	parameter logic [srb_pkg::TMR_W-1:0] QUAL_CYCLES = srb_pkg::QUAL_CYC,
	parameter logic [srb_pkg::TMR_W-1:0] BOOT_DELAY_CYCLES = srb_pkg::BOOT_DELAY_CYC,
	parameter logic [srb_pkg::TMR_W-1:0] RETRY_CYCLES = srb_pkg::RETRY_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// supply comparators, asynchronous
	input wire logic supplyAboveStartIn,
	input wire logic supplyAboveOffIn,
	// eeprom word reader
	output srb_pkg::srb_eep_req_t eepReq,
	input wire srb_pkg::srb_eep_ans_t eepAns,
	// program_ram write port
	output srb_pkg::srb_program_ram_wr_t pramWr,
	// dsp_core control
	output logic pcLoad,
	output logic [srb_pkg::PROGRAM_RAM_AW-1:0] pcAddr,
	output logic porReset,
	output logic unitsEnable,
	// audio path
	input wire logic muteRelease,
	output logic audioMute,
	output logic bootDone
);
	logic startMeta_r, startSync_r, offMeta_r, offSync_r;
	srb_sup_state_t supState_r;
	srb_boot_state_t bootState_r;
	logic qualDone, bootTmrDone, running;
	logic loadPass_r, released_r;
	logic [EEP_AW-1:0] wordIdx_r, idxLast, payIdx;
	logic [WORD_W-1:0] imgLen_r, sum_r;

	// comparator levels pass two flip-flops before use
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			startMeta_r <= 1'b0;
			startSync_r <= 1'b0;
			offMeta_r <= 1'b0;
			offSync_r <= 1'b0;
		end
		else
		begin
			startMeta_r <= supplyAboveStartIn;
			startSync_r <= startMeta_r;
			offMeta_r <= supplyAboveOffIn;
			offSync_r <= offMeta_r;
		end
	end

	// qualification: counts while above start; any dip below start begins it again
	srb_timer u_qual_tmr (
		.clk(clk),
		.rst(rst),
		.clear(!startSync_r || !offSync_r || supState_r != PS_OFF), // [RULE_11] [RULE_09] [RULE_07]
		.run(startSync_r), // [RULE_07]
		.limit(QUAL_CYCLES),
		.done(qualDone)
	);

	// supply state: leaves run only below the off level, not the start level
	always_ff @(posedge clk)
	begin
		if (rst)
			supState_r <= PS_OFF;
		else
			unique case (supState_r)
				PS_OFF: if (qualDone && startSync_r && offSync_r) supState_r <= PS_POR; // [RULE_07]
				PS_POR: supState_r <= PS_RUN;
				PS_RUN: if (!offSync_r) supState_r <= PS_OFF; // [RULE_10] [RULE_08]
			endcase
	end

	assign running = (supState_r == PS_RUN);

	// reset pulse and unit enable, both registered
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			porReset <= 1'b0;
			unitsEnable <= 1'b0;
		end
		else
		begin
			porReset <= (supState_r == PS_OFF) && qualDone && startSync_r && offSync_r; // [RULE_01]
			unitsEnable <= (supState_r == PS_POR) || (running && offSync_r); // [RULE_08]
		end
	end

	// one timer serves the start delay and the retry pause
	srb_timer u_boot_tmr (
		.clk(clk),
		.rst(rst),
		.clear(bootState_r != BT_DELAY && bootState_r != BT_RETRY),
		.run(1'b1),
		.limit(bootState_r == BT_DELAY ? BOOT_DELAY_CYCLES : RETRY_CYCLES),
		.done(bootTmrDone)
	);

	assign idxLast = imgLen_r + IMG_HDR_WORDS;
	assign payIdx = wordIdx_r - IMG_HDR_WORDS;

	// boot sequence; anything but running drops it back to idle
	always_ff @(posedge clk)
	begin
		if (rst || !running)
			bootState_r <= BT_IDLE; // [RULE_01]
		else
			unique case (bootState_r)
				BT_IDLE: bootState_r <= BT_DELAY;
				BT_DELAY: if (bootTmrDone) bootState_r <= BT_REQ; // [RULE_03]
				BT_REQ: bootState_r <= BT_WAIT;
				BT_WAIT:
				begin
					if (eepAns.err)
						bootState_r <= BT_RETRY; // [RULE_05]
					else if (eepAns.valid)
					begin
						if (wordIdx_r == IDX_MARKER && eepAns.data != BOOT_MARKER)
							bootState_r <= BT_RETRY; // [RULE_04]
						else if (wordIdx_r == IDX_LENGTH && (eepAns.data == '0 || eepAns.data > PROGRAM_RAM_DEPTH))
							bootState_r <= BT_RETRY; // [RULE_04]
						else if (wordIdx_r == idxLast && eepAns.data != sum_r)
							bootState_r <= BT_RETRY; // [RULE_04]
						else if (wordIdx_r == idxLast && loadPass_r)
							bootState_r <= BT_PC;
						else
							bootState_r <= BT_REQ;
					end
				end
				BT_PC: bootState_r <= BT_DONE; // [RULE_06]
				BT_DONE: bootState_r <= BT_DONE;
				BT_RETRY: if (bootTmrDone) bootState_r <= BT_REQ; // [RULE_12]
			endcase
	end

	// word index, length, running sum and pass; a retry starts over at word zero
	always_ff @(posedge clk)
	begin
		if (rst || bootState_r == BT_DELAY || bootState_r == BT_RETRY)
		begin
			wordIdx_r <= '0; // [RULE_12]
			loadPass_r <= 1'b0;
			imgLen_r <= '0;
			sum_r <= '0;
		end
		else if (bootState_r == BT_WAIT && eepAns.valid && !eepAns.err)
		begin
			if (wordIdx_r == IDX_LENGTH)
				imgLen_r <= eepAns.data;
			if (wordIdx_r >= IMG_HDR_WORDS && wordIdx_r < idxLast)
				sum_r <= sum_r + eepAns.data;
			if (wordIdx_r == idxLast)
			begin
				// second pass re-reads the image; no buffer needed for the check
				loadPass_r <= 1'b1; // [RULE_04]
				wordIdx_r <= '0;
				sum_r <= '0;
			end
			else
				wordIdx_r <= wordIdx_r + EEP_AW'(1);
		end
	end

	// read request, one-cycle pulse per word
	always_ff @(posedge clk)
	begin
		if (rst)
			eepReq <= '0;
		else
		begin
			eepReq.req <= running && (bootState_r == BT_REQ); // [RULE_03]
			eepReq.addr <= wordIdx_r;
		end
	end

	// program_ram writes happen only on the second, already checked, pass
	always_ff @(posedge clk)
	begin
		if (rst)
			pramWr <= '0;
		else
		begin
			pramWr.we <= running && bootState_r == BT_WAIT && eepAns.valid && !eepAns.err && loadPass_r
				&& wordIdx_r >= IMG_HDR_WORDS && wordIdx_r < idxLast; // [RULE_04]
			pramWr.addr <= payIdx[PROGRAM_RAM_AW-1:0];
			pramWr.data <= eepAns.data;
		end
	end

	// program counter load and boot status
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pcLoad <= 1'b0;
			pcAddr <= BOOT_START_ADDR;
			bootDone <= 1'b0;
		end
		else
		begin
			pcLoad <= running && (bootState_r == BT_PC); // [RULE_06]
			pcAddr <= BOOT_START_ADDR;
			bootDone <= running && (bootState_r == BT_DONE);
		end
	end

	// mute holds until booted and released; shutdown or reset mutes again
	always_ff @(posedge clk)
	begin
		if (rst || !running || bootState_r != BT_DONE)
		begin
			released_r <= 1'b0;
			audioMute <= 1'b1; // [RULE_02] [RULE_05]
		end
		else
		begin
			if (muteRelease)
				released_r <= 1'b1;
			audioMute <= !(released_r || muteRelease);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_err_seen;
		bootState_r == BT_WAIT && eepAns.err && running;
	endsequence
	sequence s_retry_muted;
		bootState_r == BT_RETRY && audioMute;
	endsequence

	property p_por_needs_qual;
		$rose(porReset) |-> $past(qualDone) && $past(supState_r == PS_OFF);
	endproperty
	a_por_needs_qual: assert property (p_por_needs_qual) else $error("reset pulse without qualification"); // [RULE_07]
	property p_por_then_enable;
		porReset |=> unitsEnable && !porReset;
	endproperty
	a_por_then_enable: assert property (p_por_then_enable) else $error("reset pulse not followed by enable"); // [RULE_01]
	property p_shutdown;
		running && !offSync_r |=> !unitsEnable ##1 (bootState_r == BT_IDLE && audioMute);
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("units not shut down below off level"); // [RULE_08]
	property p_hysteresis;
		running && offSync_r && !startSync_r |=> running;
	endproperty
	a_hysteresis: assert property (p_hysteresis) else $error("left run between levels"); // [RULE_10]
	property p_qual_restart;
		supState_r == PS_OFF && !offSync_r |=> !porReset ##1 !porReset;
	endproperty
	a_qual_restart: assert property (p_qual_restart) else $error("reset issued after early drop"); // [RULE_11]
	property p_muted_until_done;
		bootState_r != BT_DONE |=> audioMute;
	endproperty
	a_muted_until_done: assert property (p_muted_until_done) else $error("outputs unmuted before boot"); // [RULE_02]
	property p_write_checked_only;
		pramWr.we |-> $past(loadPass_r);
	endproperty
	a_write_checked_only: assert property (p_write_checked_only) else $error("write before validation"); // [RULE_04]
	property p_error_retry;
		s_err_seen |=> s_retry_muted;
	endproperty
	a_error_retry: assert property (p_error_retry) else $error("read error not muted and retried"); // [RULE_05]
	property p_pc_load;
		pcLoad |-> pcAddr == BOOT_START_ADDR && $past(bootState_r == BT_PC) ##1 bootDone;
	endproperty
	a_pc_load: assert property (p_pc_load) else $error("program counter load wrong"); // [RULE_06]
	property p_no_early_read;
		bootState_r == BT_DELAY && !bootTmrDone |=> !eepReq.req;
	endproperty
	a_no_early_read: assert property (p_no_early_read) else $error("eeprom read before start delay"); // [RULE_03]
	property p_retry_from_start;
		bootState_r == BT_RETRY && bootTmrDone && running |=> bootState_r == BT_REQ && wordIdx_r == '0 && !loadPass_r;
	endproperty
	a_retry_from_start: assert property (p_retry_from_start) else $error("retry not from first stage"); // [RULE_12]
endmodule : srb_sequencer

// >>> dv/srb_eep_model.sv
`timescale 1ns/1ps
module srb_eep_model
	import srb_pkg::*;
(
	// clock
	input wire logic clk,
	// word reader link
	input wire srb_pkg::srb_eep_req_t eepReq,
	output srb_pkg::srb_eep_ans_t eepAns,
	// pace and fault control
	input wire logic [srb_pkg::EEP_AW-1:0] errAt,
	input wire logic [3:0] lag
);
	logic [WORD_W-1:0] mem [0:15];
	logic [EEP_AW-1:0] addr_r;
	logic [3:0] cnt_r;
	logic busy_r = 1'b0;
	logic [WORD_W-1:0] last_r = 16'h0000;

	// one word per request after lag cycles; idle data shows the inverse of the last word
	always @(posedge clk)
	begin
		eepAns.valid <= 1'b0;
		eepAns.err <= 1'b0;
		eepAns.data <= ~last_r;
		if (eepReq.req === 1'b1)
		begin
			busy_r <= 1'b1;
			addr_r <= eepReq.addr;
			cnt_r <= lag;
		end
		else if (busy_r && cnt_r != 4'h0)
			cnt_r <= cnt_r - 4'h1;
		else if (busy_r)
		begin
			busy_r <= 1'b0;
			if (addr_r == errAt)
				eepAns.err <= 1'b1; // injected read fault
			else
			begin
				eepAns.valid <= 1'b1;
				eepAns.data <= mem[addr_r[3:0]];
				last_r <= mem[addr_r[3:0]];
			end
		end
	end
endmodule : srb_eep_model

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
	import srb_pkg::*;
	localparam int QC = 20;
	localparam int BD = 50;
	localparam int RT = 30;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic supplyStart = 1'b0;
	logic supplyOff = 1'b0;
	logic muteRel = 1'b0;
	logic [EEP_AW-1:0] errAt = 16'h0001;
	logic [3:0] lag = 4'h0;
	srb_eep_req_t eepReq;
	srb_eep_ans_t eepAns;
	srb_program_ram_wr_t pramWr;
	logic pcLoad, porReset, unitsEnable, audioMute, bootDone;
	logic [PROGRAM_RAM_AW-1:0] pcAddr;
	int num_errors = 0;
	int tests_run = 0;
	int wrCnt = 0;
	int c;

	srb_sequencer #(.QUAL_CYCLES(TMR_W'(QC)), .BOOT_DELAY_CYCLES(TMR_W'(BD)), .RETRY_CYCLES(TMR_W'(RT))) uut (
		.clk(clk), .rst(rst), .supplyAboveStartIn(supplyStart), .supplyAboveOffIn(supplyOff),
		.eepReq(eepReq), .eepAns(eepAns), .pramWr(pramWr), .pcLoad(pcLoad), .pcAddr(pcAddr),
		.porReset(porReset), .unitsEnable(unitsEnable), .muteRelease(muteRel), .audioMute(audioMute),
		.bootDone(bootDone));

	srb_eep_model eep (.clk(clk), .eepReq(eepReq), .eepAns(eepAns), .errAt(errAt), .lag(lag));

	// 200 MHz clock
	initial
	begin
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	// bounded wait: 0 reset pulse, 1 any request, 2 pc load, 3 request at index 0
	task automatic waitEv(input int sel, output int n);
		n = 0;
		repeat (3000)
		begin
			@(negedge clk);
			n++;
			if ((sel == 0 && porReset === 1'b1) || (sel == 1 && eepReq.req === 1'b1) || (sel == 2 && pcLoad === 1'b1)
				|| (sel == 3 && eepReq.req === 1'b1 && eepReq.addr === 16'h0000))
				return;
		end
		num_errors++;
		$display("BAD t=%0t wait sel=%h gave up", $time, sel);
		final_report();
	endtask : waitEv

	// every program_ram write must carry the matching payload word
	always @(negedge clk)
	begin
		if (pramWr.we === 1'b1)
		begin
			wrCnt++;
			chk(pramWr.data, eep.mem[pramWr.addr + 2]);
		end
	end

	// early drop must restart the qualification count
	task automatic t_power_glitch;
		supplyStart = 1'b1;
		supplyOff = 1'b1;
		repeat (10) @(negedge clk);
		supplyStart = 1'b0;
		supplyOff = 1'b0;
		repeat (5) @(negedge clk);
		supplyStart = 1'b1;
		supplyOff = 1'b1;
		waitEv(0, c);
		chk(c >= QC && c <= QC + 6, 1);
		chk({bootDone, audioMute}, 2'h1);
		$display("test power_glitch done");
	endtask : t_power_glitch

	// read fault, then a bad checksum, then a good slow boot
	task automatic t_boot;
		waitEv(1, c);
		chk(c >= BD && c <= BD + 6, 1);
		chk(eepReq.addr, 16'h0000);
		waitEv(1, c);
		waitEv(1, c);
		chk(c >= RT && c <= RT + 8, 1);
		chk(eepReq.addr, 16'h0000);
		chk(audioMute, 1'b1);
		errAt = 16'hFFFF;
		eep.mem[5] = ~eep.mem[5];
		waitEv(3, c);
		chk(wrCnt, 0);
		// oversize length, then a wrong marker: each refused at once, so the pause follows quickly
		eep.mem[5] = ~eep.mem[5];
		eep.mem[1] = 16'h3001;
		waitEv(3, c);
		chk(c >= RT && c <= RT + 10, 1);
		eep.mem[1] = 16'h0003;
		eep.mem[0] = ~BOOT_MARKER;
		waitEv(3, c);
		chk(c >= RT && c <= RT + 8, 1);
		chk(wrCnt, 0);
		eep.mem[0] = BOOT_MARKER;
		lag = 4'h4;
		waitEv(2, c);
		chk(pcAddr, 14'h0000);
		chk(wrCnt, 3);
		@(negedge clk);
		chk({bootDone, audioMute}, 2'h3);
		muteRel = 1'b1;
		repeat (3) @(negedge clk);
		chk(audioMute, 1'b0);
		$display("test boot done");
	endtask : t_boot

	// between thresholds keep running; below off level shut down; requalify after
	task automatic t_hyst;
		int i;
		supplyStart = 1'b0;
		repeat (30) @(negedge clk);
		chk(unitsEnable, 1'b1);
		supplyOff = 1'b0;
		repeat (5) @(negedge clk);
		chk({unitsEnable, audioMute, bootDone}, 3'h2);
		// off level back, start level touched too briefly to qualify; no reset pulse at any edge
		supplyOff = 1'b1;
		c = 0;
		for (i = 0; i < 45; i++)
		begin
			supplyStart = (i >= 20 && i < 32);
			@(negedge clk);
			if (porReset !== 1'b0)
				c++;
		end
		chk(c, 0);
		supplyStart = 1'b1;
		waitEv(0, c);
		chk(c >= QC && c <= QC + 6, 1);
		$display("test hysteresis done");
	endtask : t_hyst

	// image: marker, length 3, payload, checksum
	initial
	begin
		eep.mem[0] = BOOT_MARKER;
		eep.mem[1] = 16'h0003;
		eep.mem[2] = 16'h1234;
		eep.mem[3] = 16'h0FF0;
		eep.mem[4] = 16'hABCD;
		eep.mem[5] = eep.mem[2] + eep.mem[3] + eep.mem[4];
		repeat (6) @(negedge clk);
		rst = 1'b0;
		t_power_glitch();
		t_boot();
		t_hyst();
		final_report();
	end
endmodule : tb
